// ---- hw/gsc_ctrl.v ----
// generator start/stop sequencer, shutdown lockout and alarm logic
// assumes all inputs synchronous to sys_clk; apb slave for settings and status
`timescale 1ns/1ps
`include "gsc_defines.vh"
module gsc_ctrl #(
  parameter integer CLK_HZ = `GSC_CLK_HZ,
  parameter integer CRANK_TRIES = `GSC_CRANK_TRIES
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // selector and operator inputs
  input wire sel_run,
  input wire sel_stop,
  input wire sel_auto,
  input wire remote_start,
  input wire estop_local,
  input wire estop_remote,
  input wire alarm_ack,
  input wire fault_reset,
  input wire lamp_test,
  // engine sensors
  input wire engine_started,
  input wire crank_detect,
  input wire hot_coolant,
  input wire low_oil,
  input wire overspeed,
  input wire volt_bad,
  input wire freq_bad,
  input wire low_level,
  input wire cold_coolant,
  input wire oil_warn,
  input wire hot_warn,
  input wire batt_bad,
  input wire charger_alarm,
  input wire breaker_trip,
  input wire fuel_alarm,
  // engine outputs
  output reg fuel_on,
  output reg starter_on,
  output reg [2:0] run_no,
  output reg [2:0] run_nc,
  // alarm outputs and running-hours count
  output reg horn,
  output reg pre_no,
  output reg pre_nc,
  output reg sd_no,
  output reg sd_nc,
  output reg [`GSC_SD_N-1:0] sd_lamp,
  output reg [`GSC_PA_N-1:0] pre_lamp,
  output reg lockout,
  output reg [15:0] hours_tenths
);
  localparam integer COOL_MAX_SEC = `GSC_COOL_MAX_MIN * 60;
  localparam [31:0] CTRL_RST = `GSC_CTRL_RESET_VAL;
  localparam [31:0] COOL_LIMIT = `GSC_COOL_MAX_MIN;
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_CRANK = 6'h02;
  localparam [5:0] S_REST = 6'h04;
  localparam [5:0] S_RUN = 6'h08;
  localparam [5:0] S_COOL = 6'h10;
  localparam [5:0] S_FAIL = 6'h20;

  wire sec;
  reg [5:0] state;
  reg [9:0] sec_cnt;
  reg [2:0] tries;
  reg [`GSC_CTRL_COOL_W-1:0] cool_min;
  reg [`GSC_SD_N-1:0] sd_latch;
  reg [`GSC_PA_N-1:0] pa_latch;
  reg [8:0] hr_sec;
  reg ocrank_ev;
  reg nocrank_ev;
  reg sw_reset;
  reg sw_ack;
  wire [`GSC_SD_N-1:0] sd_now;
  wire [`GSC_PA_N-1:0] pa_now;
  wire estop;
  wire demand;
  wire apb_wr;

  gsc_tick #(.DIV(CLK_HZ)) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(sec)
  );

  assign estop = estop_local | estop_remote;
  // live shutdown conditions
  assign sd_now = {low_level, estop, freq_bad, volt_bad, nocrank_ev, ocrank_ev,
                   overspeed, low_oil, hot_coolant};
  // live pre-alarm conditions, remote contacts separate
  assign pa_now = {fuel_alarm, breaker_trip, charger_alarm, batt_bad, ~sel_auto,
                   hot_warn, oil_warn, cold_coolant};
  // start demand by selector position
  assign demand = ~sel_stop & (sel_run | (sel_auto & remote_start));
  assign apb_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  function [9:0] to_sec(input integer s);
    to_sec = s[9:0] - 10'h001;
  endfunction

  // sequencer
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      sec_cnt <= 10'h000;
      tries <= 3'h0;
      ocrank_ev <= 1'b0;
      nocrank_ev <= 1'b0;
    end
    else
    begin
      ocrank_ev <= 1'b0;
      nocrank_ev <= 1'b0;
      if (estop || lockout || (|sd_now) || sel_stop)
      begin
        state <= S_IDLE;
        sec_cnt <= 10'h000;
      end
      else
      begin
        case (state)
          S_IDLE:
            if (demand)
            begin
              state <= S_CRANK;
              tries <= 3'h1;
              sec_cnt <= to_sec(`GSC_CRANK_SEC);
            end
          S_CRANK:
          begin
            if (engine_started)
              state <= S_RUN;
            else if (!demand)
              state <= S_IDLE;
            else if (sec)
            begin
              if (sec_cnt == 10'h000)
              begin
                if (!crank_detect)
                  nocrank_ev <= 1'b1;
                if (tries == CRANK_TRIES[2:0])
                begin
                  state <= S_FAIL;
                  ocrank_ev <= 1'b1;
                end
                else
                begin
                  state <= S_REST;
                  sec_cnt <= to_sec(`GSC_REST_SEC);
                end
              end
              else
                sec_cnt <= sec_cnt - 10'h001;
            end
          end
          S_REST:
          begin
            if (!demand)
              state <= S_IDLE;
            else if (sec)
            begin
              if (sec_cnt == 10'h000)
              begin
                state <= S_CRANK;
                tries <= tries + 3'h1;
                sec_cnt <= to_sec(`GSC_CRANK_SEC);
              end
              else
                sec_cnt <= sec_cnt - 10'h001;
            end
          end
          S_RUN:
            if (!demand)
            begin
              if (sel_auto && cool_min != {`GSC_CTRL_COOL_W{1'b0}})
              begin
                state <= S_COOL;
                sec_cnt <= 10'h000;
              end
              else
                state <= S_IDLE;
            end
          S_COOL:
          begin
            if (demand)
              state <= S_RUN;
            else if (sec)
            begin
              if (sec_cnt + 10'h001 >= {cool_min, 6'h00} - {cool_min, 2'h0}
                  || sec_cnt == COOL_MAX_SEC[9:0])
                state <= S_IDLE;
              else
                sec_cnt <= sec_cnt + 10'h001;
            end
          end
          S_FAIL:
            state <= S_IDLE;
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end

  // shutdown/pre-alarm latching, horn, lockout
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sd_latch <= {`GSC_SD_N{1'b0}};
      pa_latch <= {`GSC_PA_N{1'b0}};
      lockout <= 1'b0;
      horn <= 1'b0;
    end
    else
    begin
      if (fault_reset || sw_reset)
      begin
        sd_latch <= sd_now;
        lockout <= |sd_now;
      end
      else
      begin
        sd_latch <= sd_latch | sd_now;
        lockout <= lockout | (|sd_now);
      end
      if (alarm_ack || sw_ack)
        pa_latch <= pa_now;
      else
        pa_latch <= pa_latch | pa_now;
      // new event beats acknowledge in the same cycle
      if ((|(sd_now & ~sd_latch)) || (|(pa_now & ~pa_latch)))
        horn <= 1'b1;
      else if (alarm_ack || sw_ack)
        horn <= 1'b0;
    end
  end

  // indicator and contact outputs
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fuel_on <= 1'b0;
      starter_on <= 1'b0;
      run_no <= 3'h0;
      run_nc <= 3'h7;
      sd_lamp <= {`GSC_SD_N{1'b0}};
      pre_lamp <= {`GSC_PA_N{1'b0}};
      pre_no <= 1'b0;
      pre_nc <= 1'b1;
      sd_no <= 1'b0;
      sd_nc <= 1'b1;
    end
    else
    begin
      fuel_on <= ~estop & (state == S_CRANK || state == S_RUN || state == S_COOL);
      starter_on <= ~estop & (state == S_CRANK) & ~engine_started;
      run_no <= {3{state != S_IDLE && state != S_FAIL}};
      run_nc <= {3{state == S_IDLE || state == S_FAIL}};
      sd_lamp <= lamp_test ? {`GSC_SD_N{1'b1}} : (sd_latch | sd_now);
      pre_lamp <= lamp_test ? {`GSC_PA_N{1'b1}} : pa_now;
      pre_no <= |pa_latch;
      pre_nc <= ~(|pa_latch);
      sd_no <= |sd_latch;
      sd_nc <= ~(|sd_latch);
    end
  end

  // running-hours meter
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hr_sec <= 9'h000;
      hours_tenths <= 16'h0000;
    end
    else if (sec && (state == S_RUN || state == S_COOL))
    begin
      if (hr_sec == `GSC_SEC_PER_TENTH_HR - 1)
      begin
        hr_sec <= 9'h000;
        hours_tenths <= hours_tenths + 16'h0001;
      end
      else
        hr_sec <= hr_sec + 9'h001;
    end
  end

  // apb writes; reset and ack bits are self-clearing pulses
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cool_min <= CTRL_RST[`GSC_CTRL_COOL_W-1:0];
      sw_reset <= 1'b0;
      sw_ack <= 1'b0;
    end
    else
    begin
      sw_reset <= 1'b0;
      sw_ack <= 1'b0;
      if (apb_wr && paddr == `GSC_ADDR_CTRL)
      begin
        if (pwdata[`GSC_CTRL_COOL_LSB+:`GSC_CTRL_COOL_W] > `GSC_COOL_MAX_MIN)
          cool_min <= COOL_LIMIT[`GSC_CTRL_COOL_W-1:0];
        else
          cool_min <= pwdata[`GSC_CTRL_COOL_LSB+:`GSC_CTRL_COOL_W];
        sw_reset <= pwdata[`GSC_CTRL_RESET_BIT];
        sw_ack <= pwdata[`GSC_CTRL_ACK_BIT];
      end
    end
  end

  // apb read mux
  always @*
  begin
    if (paddr == `GSC_ADDR_CTRL)
      prdata = {28'h0000000, cool_min};
    else if (paddr == `GSC_ADDR_STATUS)
      prdata = {22'h000000, horn, lockout, tries, state[5:1]};
    else if (paddr == `GSC_ADDR_SHUT)
      prdata = {23'h000000, sd_latch};
    else if (paddr == `GSC_ADDR_PRE)
      prdata = {24'h000000, pa_latch};
    else if (paddr == `GSC_ADDR_HOURS)
      prdata = {16'h0000, hours_tenths};
    else
      prdata = 32'h00000000;
  end
endmodule // gsc_ctrl

// ---- hw/gsc_defines.vh ----
// constants for the generator start/stop and alarm controller
// assumes a 100 MHz sys_clk; all timing is derived from it
`ifndef GSC_DEFINES_VH
`define GSC_DEFINES_VH
`define GSC_CLK_HZ 100000000
`define GSC_CRANK_SEC 15
`define GSC_REST_SEC 15
`define GSC_CRANK_TRIES 4
`define GSC_COOL_MAX_MIN 10
`define GSC_SEC_PER_TENTH_HR 360
// apb register byte addresses
`define GSC_ADDR_CTRL 12'h000
`define GSC_ADDR_STATUS 12'h004
`define GSC_ADDR_SHUT 12'h008
`define GSC_ADDR_PRE 12'h00C
`define GSC_ADDR_HOURS 12'h010
// ctrl register fields
`define GSC_CTRL_COOL_LSB 0
`define GSC_CTRL_COOL_W 4
`define GSC_CTRL_RESET_BIT 8
`define GSC_CTRL_ACK_BIT 9
`define GSC_CTRL_RESET_VAL 32'h00000005
// shutdown fault bit positions
`define GSC_SD_HOT 0
`define GSC_SD_OILP 1
`define GSC_SD_OSPD 2
`define GSC_SD_OCRANK 3
`define GSC_SD_NOCRANK 4
`define GSC_SD_VOLT 5
`define GSC_SD_FREQ 6
`define GSC_SD_ESTOP 7
`define GSC_SD_LOWLVL 8
`define GSC_SD_N 9
// pre-alarm bit positions
`define GSC_PA_COLD 0
`define GSC_PA_OILW 1
`define GSC_PA_HOTW 2
`define GSC_PA_NOAUTO 3
`define GSC_PA_BATT 4
`define GSC_PA_CHG 5
`define GSC_PA_BRK 6
`define GSC_PA_FUEL 7
`define GSC_PA_N 8
`endif

// ---- hw/gsc_tick.v ----
// one-cycle enable pulse every DIV clocks
// assumes a free-running sys_clk
`timescale 1ns/1ps
module gsc_tick #(
  parameter integer DIV = 100000000
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // output
  output reg tick
);
  reg [31:0] cnt;
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end
    else if (cnt == DIV - 1)
    begin
      cnt <= 32'h00000000;
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule // gsc_tick

// ---- verification/gsc_engine_model.sv ----
// engine stand-in: turns while cranked, fires, stops without fuel
// driven by the controller's starter and fuel outputs
`timescale 1ns/1ps
module gsc_engine_model #(
  parameter integer FIRE_CYC = 20
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // controller side
  input wire starter_on,
  input wire fuel_on,
  input wire will_start,
  // sensor side
  output reg engine_started,
  output reg crank_detect
);
  integer spin;
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      spin <= 0;
      engine_started <= 1'b0;
      crank_detect <= 1'b0;
    end
    else
    begin
      crank_detect <= starter_on;
      spin <= starter_on ? spin + 1 : 0;
      if (!fuel_on)
        engine_started <= 1'b0;
      else if (will_start && spin >= FIRE_CYC)
        engine_started <= 1'b1;
    end
endmodule // gsc_engine_model

// ---- verification/gsc_sva.sv ----
// assertion checker for the generator controller ports
// bound to every gsc_ctrl instance; one clock, async reset
`timescale 1ns/1ps
module gsc_sva #(
  parameter integer CLK_HZ = 100,
  parameter integer CRANK_TRIES = 4
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // watched inputs
  input wire sel_stop,
  input wire estop_local,
  input wire estop_remote,
  input wire hot_coolant,
  input wire low_oil,
  input wire overspeed,
  input wire fault_reset,
  input wire psel,
  // watched outputs
  input wire fuel_on,
  input wire starter_on,
  input wire [2:0] run_no,
  input wire [2:0] run_nc,
  input wire sd_no,
  input wire sd_nc,
  input wire pre_no,
  input wire pre_nc,
  input wire lockout,
  input wire [15:0] hours_tenths
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // one crank period plus a tick of slack
  localparam int crank_max = 16 * CLK_HZ;
  integer crank_len;
  always @(posedge sys_clk or posedge rst)
    if (rst)
      crank_len <= 0;
    else
      crank_len <= starter_on ? crank_len + 1 : 0;
  property p_estop;
    estop_local || estop_remote |-> ##[1:2] !fuel_on && !starter_on;
  endproperty
  a_estop: assert property (p_estop) else $error("fuel not cut on estop");
  property p_sensor;
    hot_coolant || low_oil || overspeed |-> ##[1:2] !fuel_on;
  endproperty
  a_sensor: assert property (p_sensor) else $error("no stop on sensor");
  property p_stop;
    sel_stop |-> ##[1:2] !starter_on;
  endproperty
  a_stop: assert property (p_stop) else $error("cranking in stop");
  property p_lock;
    lockout |-> !$rose(starter_on);
  endproperty
  a_lock: assert property (p_lock) else $error("start under lockout");
  property p_run;
    $rose(starter_on) |-> run_no == 3'h7;
  endproperty
  a_run: assert property (p_run) else $error("run outputs late");
  property p_run_nc;
    run_nc == ~run_no;
  endproperty
  a_run_nc: assert property (p_run_nc) else $error("run contacts not complements");
  property p_pre_nc;
    pre_nc != pre_no;
  endproperty
  a_pre_nc: assert property (p_pre_nc) else $error("pre-alarm contacts equal");
  property p_sd_nc;
    sd_nc != sd_no;
  endproperty
  a_sd_nc: assert property (p_sd_nc) else $error("shutdown contacts equal");
  property p_crank;
    crank_len <= crank_max;
  endproperty
  a_crank: assert property (p_crank) else $error("crank period too long");
  property p_hours;
    $changed(hours_tenths) |-> hours_tenths == $past(hours_tenths) + 16'h0001;
  endproperty
  a_hours: assert property (p_hours) else $error("hour counter jumped");
  property p_lock_hold;
    lockout && !fault_reset && !$past(fault_reset) && !psel && !$past(psel) |=> lockout;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout lost");
endmodule // gsc_sva
bind gsc_ctrl gsc_sva #(.CLK_HZ(CLK_HZ), .CRANK_TRIES(CRANK_TRIES)) i_gsc_sva (.sys_clk, .rst,
  .sel_stop, .estop_local, .estop_remote, .hot_coolant, .low_oil, .overspeed, .fault_reset,
  .psel, .fuel_on, .starter_on, .run_no, .run_nc, .sd_no, .sd_nc, .pre_no, .pre_nc, .lockout,
  .hours_tenths);

// ---- verification/tb.sv ----
// self-checking bench for gsc_ctrl with the engine stand-in
// apb master and panel drive note expectations; a monitor compares them
`timescale 1ns/1ps
module tb;
  localparam [31:0] fu = 32'h80, st = 32'h40, rn = 32'h700, ho = 32'h20, lk = 32'h10;
  localparam [31:0] sn = 32'h08, sc = 32'h04, pn = 32'h02, pc = 32'h01;
  localparam [31:0] sl = 32'h0FF80000, pl = 32'h0007F800, na = 32'h00004000;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd = 32'h0, seed = 32'd9982;
  reg [2:0] sel = 3'h1;
  reg remote_start = 1'b0, ack = 1'b0, frst = 1'b0, lamp_test = 1'b0, will = 1'b1;
  reg [8:0] sdi = 9'h000;
  reg [7:0] pai = 8'h00;
  reg [64:0] q[$];
  reg [64:0] nt;
  integer fails = 0, n_compared = 0, i, k;
  wire pready, pslverr, fuel_on, starter_on, horn, pre_no, pre_nc, sd_no, sd_nc, lockout;
  wire engine_started, crank_detect;
  wire [31:0] prdata;
  wire [2:0] run_no, run_nc;
  wire [8:0] sd_lamp;
  wire [7:0] pre_lamp;
  wire [15:0] hours_tenths;
  wire [31:0] obs = {hours_tenths[3:0], sd_lamp, pre_lamp, run_no, fuel_on, starter_on, horn, lockout,
    sd_no, sd_nc, pre_no, pre_nc};
  gsc_ctrl #(.CLK_HZ(10)) i_gsc_ctrl (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .sel_run(sel[2]), .sel_stop(sel[1]),
    .sel_auto(sel[0]), .remote_start, .estop_local(sdi[7]), .estop_remote(sdi[3]),
    .alarm_ack(ack), .fault_reset(frst), .lamp_test, .engine_started, .crank_detect,
    .hot_coolant(sdi[0]), .low_oil(sdi[1]), .overspeed(sdi[2]), .volt_bad(sdi[5]),
    .freq_bad(sdi[6]), .low_level(sdi[8]), .cold_coolant(pai[0]), .oil_warn(pai[1]),
    .hot_warn(pai[2]), .batt_bad(pai[4]), .charger_alarm(pai[5]), .breaker_trip(pai[6]),
    .fuel_alarm(pai[7]), .fuel_on, .starter_on, .run_no, .run_nc, .horn, .pre_no, .pre_nc,
    .sd_no, .sd_nc, .sd_lamp, .pre_lamp, .lockout, .hours_tenths);
  gsc_engine_model i_gsc_engine_model (.sys_clk, .rst, .starter_on, .fuel_on,
    .will_start(will), .engine_started, .crank_detect);
  always #5 sys_clk = ~sys_clk;
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task note(input [31:0] m, input [31:0] e);
    q.push_back({1'b0, m, e});
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, input [31:0] m, input [31:0] e);
    integer t;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      for (t = 0; t < 20 && pready !== 1'b1; t = t + 1)
        @(posedge sys_clk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
      if (t < 20)
      begin
        if (!w)
          q.push_back({1'b1, m, e});
      end
      else
      begin
        fails = fails + 1;
        final_report;
      end
    end
  endtask
  // clears lockout and silences the horn
  task clr;
    begin
      frst <= 1'b1;
      ack <= 1'b1;
      cyc(1);
      frst <= 1'b0;
      ack <= 1'b0;
      cyc(4);
    end
  endtask
  always @(negedge sys_clk)
    while (q.size() > 0)
    begin
      nt = q.pop_front();
      chk((nt[64] ? rd : obs) & nt[63:32], nt[31:0] & nt[63:32]);
    end
  initial
  begin
    cyc(5);
    rst <= 1'b0;
    cyc(2);
    note(32'h0FFFFFFF, sc | pc);
    apb(1'b0, 12'h000, 32'h0, 32'h0F, 32'h05);
    seed = xs(seed);
    apb(1'b1, 12'h020, seed, 32'h0, 32'h0);
    apb(1'b0, 12'h020, 32'h0, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, 12'h000, 32'h0F, 32'h0, 32'h0);
    apb(1'b0, 12'h000, 32'h0, 32'h0F, 32'h0A);
    $display("test registers done");
    for (k = 0; k < 2; k = k + 1)
    begin
      apb(1'b1, 12'h000, k, 32'h0, 32'h0);
      remote_start <= 1'b1;
      cyc(4);
      note(fu | st | rn, fu | st | rn);
      cyc(60);
      note(fu | st, fu);
      remote_start <= 1'b0;
      if (k)
      begin
        cyc(580);
        note(fu, fu);
      end
      cyc(k ? 40 : 4);
      note(fu | rn, 32'h0);
    end
    $display("test auto start and cool-down done");
    will <= 1'b0;
    remote_start <= 1'b1;
    cyc(100);
    note(st, st);
    cyc(125);
    note(st, 32'h0);
    cyc(775);
    note(st, st);
    cyc(150);
    note(st | lk | ho | sn | sc | sl, lk | ho | sn | 32'h00400000);
    remote_start <= 1'b0;
    sel <= 3'h4;
    cyc(50);
    note(st | lk, lk);
    sel <= 3'h1;
    frst <= 1'b1;
    cyc(1);
    frst <= 1'b0;
    cyc(4);
    note(lk | ho | sl, ho);
    ack <= 1'b1;
    cyc(1);
    ack <= 1'b0;
    cyc(4);
    note(ho | pl, 32'h0);
    $display("test overcrank done");
    will <= 1'b1;
    sel <= 3'h4;
    for (i = 0; i < 9; i = i + 1)
      if (i != 4)
      begin
        clr;
        cyc(i ? 80 : 3700);
        note(fu | st | lk, fu);
        if (!i)
          note(32'hF0000000, 32'h10000000);
        if (!i)
          apb(1'b0, 12'h010, 32'h0, 32'h0000FFFF, 32'h1);
        sdi[i] <= 1'b1;
        cyc(4);
        note(fu | st | lk | sn | sc | sl, lk | sn | (32'h00080000 << (i == 3 ? 7 : i)));
        sdi[i] <= 1'b0;
        cyc(4);
        note(lk | sl, lk | (32'h00080000 << (i == 3 ? 7 : i)));
      end
    apb(1'b1, 12'h000, 32'h00000301, 32'h0, 32'h0);
    cyc(2);
    note(lk | ho | sl, 32'h0);
    $display("test shutdowns done");
    clr;
    sel <= 3'h2;
    remote_start <= 1'b1;
    cyc(20);
    note(fu | st | na, na);
    lamp_test <= 1'b1;
    cyc(3);
    note(sl | pl, sl | pl);
    lamp_test <= 1'b0;
    cyc(3);
    note(sl | pl, na);
    $display("test stop and lamp test done");
    remote_start <= 1'b0;
    sel <= 3'h1;
    clr;
    seed = xs(seed);
    for (i = 0; i < 8; i = i + 1)
    begin
      k = (i + seed[2:0]) % 8;
      if (k != 3)
      begin
        pai[k] <= 1'b1;
        cyc(4);
        note(pl | ho | pn | pc, (32'h00000800 << k) | ho | pn);
        pai[k] <= 1'b0;
        cyc(4);
        note(pl | ho, ho);
        clr;
        note(ho, 32'h0);
      end
    end
    $display("test pre-alarms done");
    cyc(2);
    final_report;
  end
  initial
  begin
    cyc(100000);
    fails = fails + 1;
    final_report;
  end
endmodule // tb
